// file: hw/ssc_ctrl.sv
/*
 * Supply control slave: I2C register access plus output select logic.
 * Assumes open-drain SDA resolved outside; all pins but mclk_i and sys_rst_i asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module ssc_ctrl
    import ssc_pkg::*;
#(
    parameter int T_OFF_P = ssc_pkg::T_OFF_CYC,
    parameter int T_ON_P  = ssc_pkg::T_ON_CYC
) (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic [1:0] addr_sel_i,
    input  wire logic       undervoltage_lockout_i,
    input  wire logic       tone_gate_in_i,
    input  wire logic       tone_sense_in_i,
    input  wire logic       overtemp_i,
    input  wire logic       overcurrent_i,
    output logic            tone_detect_out_o,
    output logic            tone_on_o,
    output logic            receive_supply_out_o,
    output logic            transmit_supply_out_o,
    output logic            level_high_o,
    output logic            line_drop_comp_o,
    output logic            current_limit_static_sel_o,
    output logic            power_enable_o
);
    import ssc_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [6:0] s1_ff, s2_ff;
    logic [1:0] as1_ff, as2_ff;
    always_ff @(posedge mclk_i) begin
        s1_ff  <= {scl_i, sda_i, undervoltage_lockout_i, tone_gate_in_i,
                   tone_sense_in_i, overtemp_i, overcurrent_i};
        s2_ff  <= s1_ff;
        as1_ff <= addr_sel_i;
        as2_ff <= as1_ff;
    end
    logic scl_s, sda_s, uvl_s, gate_s, sense_s, ot_s, oc_s;
    assign {scl_s, sda_s, uvl_s, gate_s, sense_s, ot_s, oc_s} = s2_ff;

    // ----------------------------------------------------------------
    // Bus engine
    // ----------------------------------------------------------------
    ssc_state_t st_ff, nxt_st;
    logic       scl_d_ff, sda_d_ff, nxt_scl_d, nxt_sda_d;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] sh_ff, nxt_sh;
    logic       rd_ff, nxt_rd;
    logic [5:0] cfg_ff, nxt_cfg;
    logic       sdo_ff, nxt_sdo;
    logic       olf_ff, nxt_olf;
    logic [7:0] reg_val;
    logic       rise, fall, start_c, stop_c;

    assign rise    = scl_s & ~scl_d_ff;
    assign fall    = ~scl_s & scl_d_ff;
    assign start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_c  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    // Overtemp flag live, overload flag held by protection, writable bits as last written
    assign reg_val = {cfg_ff, ot_s, olf_ff};

    always_comb begin
        nxt_st    = st_ff;
        nxt_scl_d = scl_s;
        nxt_sda_d = sda_s;
        nxt_cnt   = cnt_ff;
        nxt_sh    = sh_ff;
        nxt_rd    = rd_ff;
        nxt_cfg   = cfg_ff;
        nxt_sdo   = sdo_ff;
        if (uvl_s) begin
            // Lockout ignores traffic and clears config
            nxt_st  = SSC_IDLE;
            nxt_cfg = SSC_REG_RST[7:2];
            nxt_sdo = 1'b0;
        end else if (start_c) begin
            nxt_st  = SSC_ADDR;
            nxt_cnt = 4'h0;
            nxt_sdo = 1'b0;
        end else if (stop_c) begin
            nxt_st  = SSC_IDLE;
            nxt_sdo = 1'b0;
        end else begin
            unique case (st_ff)
                SSC_IDLE: ;
                SSC_ADDR, SSC_WDATA: begin
                    if (rise) begin
                        nxt_sh  = {sh_ff[6:0], sda_s};
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                    if (fall && cnt_ff == 4'h8) begin
                        nxt_cnt = 4'h0;
                        if (st_ff == SSC_WDATA) begin
                            // Only writable bits stored
                            nxt_cfg = sh_ff[7:2];
                            nxt_sdo = 1'b1;
                            nxt_st  = SSC_ACK;
                        end else if (sh_ff[7:1] ==
                                     (SSC_ADDR_BASE | {5'h00, as2_ff})) begin
                            // Address match, low bit is direction
                            nxt_rd  = sh_ff[0];
                            nxt_sdo = 1'b1;
                            nxt_st  = SSC_ACK;
                        end else begin
                            nxt_st  = SSC_IDLE;
                        end
                    end
                end
                SSC_ACK: begin
                    if (fall) begin
                        if (rd_ff) begin
                            nxt_sh  = {reg_val[6:0], 1'b0};
                            nxt_sdo = ~reg_val[7];
                            nxt_cnt = 4'h1;
                            nxt_st  = SSC_RDATA;
                        end else begin
                            nxt_sdo = 1'b0;
                            nxt_st  = SSC_WDATA;
                        end
                    end
                end
                SSC_RDATA: begin
                    if (fall) begin
                        if (cnt_ff == 4'h8) begin
                            nxt_sdo = 1'b0;
                            nxt_st  = SSC_RACK;
                        end else begin
                            nxt_sdo = ~sh_ff[7];
                            nxt_sh  = {sh_ff[6:0], 1'b0};
                            nxt_cnt = cnt_ff + 4'h1;
                        end
                    end
                end
                SSC_RACK: begin
                    // Host ack sends another copy, nack ends
                    if (rise) begin
                        nxt_st = sda_s ? SSC_IDLE : SSC_ACK;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pulsed overload protection
    // ----------------------------------------------------------------
    ssc_prot_t           pst_ff, nxt_pst;
    logic [TMR_W-1:0]    tmr_ff, nxt_tmr;
    logic                cut;
    always_comb begin
        nxt_pst = pst_ff;
        nxt_tmr = tmr_ff;
        nxt_olf = olf_ff;
        if (cfg_ff[SSC_BIT_LIMIT - 2] || !cfg_ff[SSC_BIT_EN - 2]) begin
            // Static clamp or disabled: flag follows overload while enabled
            nxt_pst = SSC_P_ON;
            nxt_olf = oc_s & cfg_ff[SSC_BIT_EN - 2];
        end else begin
            unique case (pst_ff)
                SSC_P_ON: if (oc_s) begin
                    nxt_pst = SSC_P_OFF;
                    nxt_tmr = TMR_W'(T_OFF_P);
                    nxt_olf = 1'b1;
                end
                SSC_P_OFF: if (tmr_ff <= 1) begin
                    nxt_pst = SSC_P_TRY;
                    nxt_tmr = TMR_W'(T_ON_P);
                end else begin
                    nxt_tmr = tmr_ff - 1'b1;
                end
                SSC_P_TRY: if (oc_s) begin
                    nxt_pst = SSC_P_OFF;
                    nxt_tmr = TMR_W'(T_OFF_P);
                end else if (tmr_ff <= 1) begin
                    nxt_pst = SSC_P_ON;
                    nxt_olf = 1'b0;
                end else begin
                    nxt_tmr = tmr_ff - 1'b1;
                end
            endcase
        end
    end
    assign cut = (pst_ff == SSC_P_OFF) | ot_s;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_ff    <= SSC_IDLE;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            cnt_ff   <= 4'h0;
            sh_ff    <= 8'h00;
            rd_ff    <= 1'b0;
            cfg_ff   <= SSC_REG_RST[7:2];
            sdo_ff   <= 1'b0;
            olf_ff   <= 1'b0;
            pst_ff   <= SSC_P_ON;
            tmr_ff   <= '0;
        end else begin
            st_ff    <= nxt_st;
            scl_d_ff <= nxt_scl_d;
            sda_d_ff <= nxt_sda_d;
            cnt_ff   <= nxt_cnt;
            sh_ff    <= nxt_sh;
            rd_ff    <= nxt_rd;
            cfg_ff   <= nxt_cfg;
            sdo_ff   <= nxt_sdo;
            olf_ff   <= nxt_olf;
            pst_ff   <= nxt_pst;
            tmr_ff   <= nxt_tmr;
        end
    end

    // ----------------------------------------------------------------
    // Supply outputs, all registered
    // ----------------------------------------------------------------
    logic en;
    assign en = cfg_ff[SSC_BIT_EN - 2] & ~cut;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sda_o                      <= 1'b0;
            sda_oe_o                   <= 1'b0;
            tone_detect_out_o          <= 1'b0;
            tone_on_o                  <= 1'b0;
            receive_supply_out_o       <= 1'b0;
            transmit_supply_out_o      <= 1'b0;
            level_high_o               <= 1'b0;
            line_drop_comp_o           <= 1'b0;
            current_limit_static_sel_o <= 1'b0;
            power_enable_o             <= 1'b0;
        end else begin
            sda_o    <= 1'b0;
            sda_oe_o <= nxt_sdo;
            tone_detect_out_o <= sense_s;
            // Tone forced or gated by pin
            tone_on_o <= en & cfg_ff[SSC_BIT_TXSEL - 2] &
                         (cfg_ff[SSC_BIT_TONE - 2] | gate_s);
            receive_supply_out_o  <= en & ~cfg_ff[SSC_BIT_TXSEL - 2];
            transmit_supply_out_o <= en & cfg_ff[SSC_BIT_TXSEL - 2];
            level_high_o     <= en & cfg_ff[SSC_BIT_LEVEL - 2];
            line_drop_comp_o <= en & cfg_ff[SSC_BIT_COMP - 2];
            current_limit_static_sel_o <= cfg_ff[SSC_BIT_LIMIT - 2];
            power_enable_o   <= en;
        end
    end
endmodule
`default_nettype wire

// file: hw/ssc_pkg.sv
/*
 * Constants for the supply control I2C slave: address, register layout,
 * reset value and protection timing.
 * Assumes a single 40 MHz clock; SCL and SDA are sampled, not used as clocks.
 */
package ssc_pkg;
    // --------------------------------------------------------------
    // Address and register layout
    // --------------------------------------------------------------
    localparam logic [6:0] SSC_ADDR_BASE  = 7'h08;
    localparam logic [7:0] SSC_REG_RST    = 8'h00;
    localparam int         SSC_BIT_LIMIT  = 7;
    localparam int         SSC_BIT_TXSEL  = 6;
    localparam int         SSC_BIT_TONE   = 5;
    localparam int         SSC_BIT_COMP   = 4;
    localparam int         SSC_BIT_LEVEL  = 3;
    localparam int         SSC_BIT_EN     = 2;
    localparam int         SSC_BIT_OTF    = 1;
    localparam int         SSC_BIT_OLF    = 0;
    localparam logic [7:0] SSC_WR_MASK    = 8'hfc;
    // --------------------------------------------------------------
    // Pulsed protection timing
    // --------------------------------------------------------------
    localparam int CLK_HZ      = 40000000;
    localparam int T_OFF_MS    = 900;
    localparam int T_OFF_CYC   = (CLK_HZ / 1000) * T_OFF_MS;
    localparam int T_ON_CYC    = T_OFF_CYC / 10;
    localparam int TMR_W       = 26;

    typedef enum logic [2:0] {
        SSC_IDLE, SSC_ADDR, SSC_ACK, SSC_WDATA, SSC_RDATA, SSC_RACK
    } ssc_state_t;
    typedef enum logic [1:0] {SSC_P_ON, SSC_P_OFF, SSC_P_TRY} ssc_prot_t;
endpackage

// file: tb/ssc_ctrl_assertions.sv
/* Port checker for ssc_ctrl, bound to every instance.
   Assumes one mclk_i domain with synchronous reset sys_rst_i. */
`timescale 1ns/1ps
`default_nettype none
module ssc_ctrl_assertions (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic scl_i,
    input wire logic sda_oe_o,
    input wire logic undervoltage_lockout_i,
    input wire logic tone_gate_in_i,
    input wire logic tone_sense_in_i,
    input wire logic overtemp_i,
    input wire logic tone_detect_out_o,
    input wire logic tone_on_o,
    input wire logic receive_supply_out_o,
    input wire logic transmit_supply_out_o,
    input wire logic power_enable_o,
    input wire logic level_high_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // Eight samples leave room for the input synchronisers
    sequence s_lock; undervoltage_lockout_i [*8]; endsequence
    sequence s_hot; overtemp_i [*8]; endsequence
    sequence s_gate; (transmit_supply_out_o && tone_gate_in_i) [*8]; endsequence
    property p_rst; $fell(sys_rst_i) |-> !power_enable_o && !level_high_o
        && !transmit_supply_out_o && !receive_supply_out_o; endproperty
    a_rst: assert property (p_rst)
        else $error("output set after reset");
    property p_lock; s_lock |-> !sda_oe_o && !power_enable_o; endproperty
    a_lock: assert property (p_lock)
        else $error("active during lockout");
    property p_hot; s_hot |-> !power_enable_o; endproperty
    a_hot: assert property (p_hot)
        else $error("power on while hot");
    property p_gate; s_gate |-> tone_on_o; endproperty
    a_gate: assert property (p_gate)
        else $error("tone ignores gate");
    property p_tone; tone_on_o |-> transmit_supply_out_o; endproperty
    a_tone: assert property (p_tone)
        else $error("tone without transmit output");
    property p_rxtx; receive_supply_out_o |-> !transmit_supply_out_o;
    endproperty
    a_rxtx: assert property (p_rxtx)
        else $error("both outputs on");
    property p_off; !power_enable_o |-> !receive_supply_out_o
        && !transmit_supply_out_o; endproperty
    a_off: assert property (p_off)
        else $error("output on in standby");
    property p_ack; $rose(sda_oe_o) |-> !scl_i; endproperty
    a_ack: assert property (p_ack)
        else $error("data driven with clock high");
    property p_hold; scl_i && $past(scl_i) |-> $stable(sda_oe_o); endproperty
    a_hold: assert property (p_hold)
        else $error("data moved with clock high");
    property p_det; tone_detect_out_o == $past(tone_sense_in_i, 3); endproperty
    a_det: assert property (p_det)
        else $error("detect output not sense delayed");
endmodule
bind ssc_ctrl ssc_ctrl_assertions u_ssc_ctrl_assertions (
    .mclk_i                 (mclk_i),
    .sys_rst_i              (sys_rst_i),
    .scl_i                  (scl_i),
    .sda_oe_o               (sda_oe_o),
    .undervoltage_lockout_i (undervoltage_lockout_i),
    .tone_gate_in_i         (tone_gate_in_i),
    .tone_sense_in_i        (tone_sense_in_i),
    .overtemp_i             (overtemp_i),
    .tone_detect_out_o      (tone_detect_out_o),
    .tone_on_o              (tone_on_o),
    .receive_supply_out_o   (receive_supply_out_o),
    .transmit_supply_out_o  (transmit_supply_out_o),
    .power_enable_o         (power_enable_o),
    .level_high_o           (level_high_o)
);
`default_nettype wire

// file: tb/ssc_host.sv
/* Host bus master model: start, stop and nine-bit byte slots.
   Assumes a pull-up on the data line; drives at the falling mclk edge. */
`timescale 1ns/1ps
`default_nettype none
module ssc_host (
    input  wire logic mclk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // Start when go, else stop: data edge with clock high
    task automatic cond(input logic go);
        sda_low_o = !go;
        hold(4);
        scl_o = 1'b1;
        hold(6);
        sda_low_o = go;
        hold(6);
        scl_o = !go;
        hold(4);
    endtask
    // MSB first plus ack slot, 200 ns per bit
    // Four low cycles cover the slave's three-cycle answer latency
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_low_o = !tx[i];
            hold(3);
            scl_o = 1'b1;
            hold(2);
            rx[i] = sda_i;
            hold(2);
            scl_o = 1'b0;
            hold(1);
        end
    endtask
endmodule
`default_nettype wire

// file: tb/sat_supply_i2c_control_tb_top.sv
/* Top testbench: register traffic through the host model, output checks.
   Assumes short protection timer values passed as parameters. */
`timescale 1ns/1ps
`default_nettype none
module sat_supply_i2c_control_tb_top;
    import ssc_pkg::*;
    logic       mclk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [1:0] addr_sel = 2'h0;
    logic       uvlo = 1'b0, gate = 1'b0, sense = 1'b0, hot = 1'b0;
    logic       ovc = 1'b0;
    logic       scl, host_low, sda_oe, sda_q, det, tone, rx_o, tx_o;
    logic       lvl, comp, lim, pwr;
    logic [8:0] rx;
    wire        sda = !(host_low || (sda_oe && !sda_q));
    wire  [7:0] outs = {lim, tx_o, tone, comp, lvl, pwr, rx_o, det};
    wire  [7:0] pw = {4'h0, tx_o, tone, pwr, rx_o};
    int         miscompares = 0;
    int         total_checks = 0;
    int         cyc = 0;
    always #12.5 mclk_i = !mclk_i;
    ssc_ctrl #(.T_OFF_P(400), .T_ON_P(40)) u_ssc_ctrl (.mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_q), .sda_oe_o(sda_oe),
        .addr_sel_i(addr_sel), .undervoltage_lockout_i(uvlo),
        .tone_gate_in_i(gate), .tone_sense_in_i(sense), .overtemp_i(hot),
        .overcurrent_i(ovc), .tone_detect_out_o(det), .tone_on_o(tone),
        .receive_supply_out_o(rx_o), .transmit_supply_out_o(tx_o),
        .level_high_o(lvl), .line_drop_comp_o(comp),
        .current_limit_static_sel_o(lim), .power_enable_o(pwr));
    ssc_host u_ssc_host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl),
        .sda_low_o(host_low));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Ack bit reads low when taken
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic ok);
        u_ssc_host.cond(1'b1);
        u_ssc_host.xfer({a, 2'b01}, rx);
        chk(8'(rx[0]), 8'(!ok));
        u_ssc_host.xfer({d, 1'b1}, rx);
        chk(8'(rx[0]), 8'(!ok));
        u_ssc_host.cond(1'b0);
    endtask
    // Host acks every byte but the last
    task automatic rd(input logic [7:0] exp, input int n);
        u_ssc_host.cond(1'b1);
        u_ssc_host.xfer(9'h023, rx);
        chk(8'(rx[0]), 8'h00);
        for (int i = n; i > 0; i--) begin
            u_ssc_host.xfer({8'hff, i == 1}, rx);
            chk(rx[8:1], exp);
        end
        u_ssc_host.cond(1'b0);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        u_ssc_host.hold(3);
        sys_rst_i = 1'b0;
        u_ssc_host.hold(4);
        rd(8'h00, 1);
        chk(outs, 8'h00);
        wr(7'h08, 8'h04, 1'b1);
        chk(outs, 8'h06);
        wr(7'h08, 8'hff, 1'b1);
        chk(outs, 8'hfc);
        rd(8'hfc, 2);
        wr(7'h08, 8'h44, 1'b1);
        chk(outs, 8'h44);
        gate = 1'b1;
        u_ssc_host.hold(10);
        chk(outs, 8'h64);
        gate = 1'b0;
        wr(7'h08, 8'hf8, 1'b1);
        chk(pw, 8'h00);
        for (int s = 0; s < 4; s++) begin
            addr_sel = 2'(s);
            wr(7'h08 + 7'(s), 8'h04, 1'b1);
            wr(7'h08 + 7'(2'(s + 1)), 8'h0c, 1'b0);
            chk(outs, 8'h06);
        end
        addr_sel = 2'h0;
        sense = 1'b1;
        u_ssc_host.hold(5);
        chk(8'(det), 8'h01);
        sense = 1'b0;
        hot = 1'b1;
        rd(8'h06, 1);
        chk(8'(pwr), 8'h00);
        hot = 1'b0;
        wr(7'h08, 8'h84, 1'b1);
        ovc = 1'b1;
        rd(8'h85, 1);
        ovc = 1'b0;
        rd(8'h84, 1);
        // Short overload in pulsed mode: flag outlives the fault
        wr(7'h08, 8'h04, 1'b1);
        ovc = 1'b1;
        u_ssc_host.hold(5);
        ovc = 1'b0;
        rd(8'h05, 1);
        u_ssc_host.hold(600);
        rd(8'h04, 1);
        uvlo = 1'b1;
        u_ssc_host.hold(10);
        wr(7'h08, 8'hfc, 1'b0);
        chk(outs, 8'h00);
        uvlo = 1'b0;
        u_ssc_host.hold(10);
        rd(8'h00, 1);
        wr(7'h08, 8'h04, 1'b1);
        chk(outs, 8'h06);
        test_done();
    end
endmodule
`default_nettype wire
